// >>> verilog/bip_port.sv
// Purpose: Two eight-pin general purpose I/O ports with external interrupts.
// Assumes: Single clock; all inputs synchronous; plain strobe register port.
// Notes: Each pin has direction, option and data bits; triggers are per port.
//
// What this block does
// - Ports have up to eight pins, each configured independently of the others.
// - Direction, option and data registers per port; bit n controls pin n.
// - Reset clears all port registers: input, pull-up, no interrupt.
// - Direction 0 makes an input; data reads return the pin level.
// - Direction 1 makes an output; written data latched, driven, read back.
// - Input modes by option,data: 00 pull-up, 01 none, 10 interrupt, 11 analog.
// - Output option 0 open-drain, 1 push-pull; data does not pick the mode.
// - Push-pull drives both levels; open-drain drives low only, else floats.
// - Interrupt-configured inputs feed interrupts; trigger kind chosen per port.
// - A peripheral reaches a pin only after software configures that pin.
// - Port A select: 0 falling edge, 1 low level; port B: 0 fall, 1 rise.
// - Pin events interrupt only when configured and global enable is set.

`timescale 1ns/1ps
`default_nettype none

module bip_port
    import bip_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port.
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // Port A pins.
    input wire logic [7:0] a_pin_in,
    output logic [7:0] a_pin_out,
    output logic [7:0] a_pin_oe_out,
    output logic [7:0] a_pull_up_out,
    output logic [7:0] a_analog_out,
    // Port B pins.
    input wire logic [7:0] b_pin_in,
    output logic [7:0] b_pin_out,
    output logic [7:0] b_pin_oe_out,
    output logic [7:0] b_pull_up_out,
    output logic [7:0] b_analog_out,
    // Alternate function requests from peripherals.
    input wire logic [7:0] a_alt_req_in,
    input wire logic [7:0] a_alt_val_in,
    input wire logic [7:0] b_alt_req_in,
    input wire logic [7:0] b_alt_val_in,
    // Interrupt request.
    output logic irq_out
);

    // Port configuration registers.
    logic [7:0] a_latch_r;
    logic [7:0] a_dir_r;
    logic [7:0] a_opt_r;
    logic [7:0] b_latch_r;
    logic [7:0] b_dir_r;
    logic [7:0] b_opt_r;

    // Interrupt control, status and mask.
    logic port_a_level_select_r;
    logic port_b_polarity_select_r;
    logic global_irq_enable_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_stat_nxt;
    logic [1:0] irq_mask_r;

    // Per-pin combinational results.
    logic [7:0] a_read;
    logic [7:0] a_fall;
    logic [7:0] a_rise;
    logic [7:0] a_low;
    logic [7:0] b_read;
    logic [7:0] b_fall;
    logic [7:0] b_rise;
    logic [7:0] b_low;

    // Port-level trigger events.
    logic a_event;
    logic b_event;
    logic [1:0] events;
    logic stat_rd;
    logic [7:0] rd_data_nxt;

    // One pin cell per bit, all alike and independent.
    genvar gi;
    generate
        for (gi = 0; gi < BIP_PINS; gi = gi + 1) begin : g_pin
            // Port A pin.
            bip_pin u_a (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .dir_in(a_dir_r[gi]),
                .opt_in(a_opt_r[gi]),
                .latch_in(a_latch_r[gi]),
                .alt_req_in(a_alt_req_in[gi]),
                .alt_val_in(a_alt_val_in[gi]),
                .pin_in(a_pin_in[gi]),
                .pin_out(a_pin_out[gi]),
                .pin_oe_out(a_pin_oe_out[gi]),
                .pull_up_out(a_pull_up_out[gi]),
                .analog_out(a_analog_out[gi]),
                .read_bit_out(a_read[gi]),
                .fall_out(a_fall[gi]),
                .rise_out(a_rise[gi]),
                .low_out(a_low[gi])
            );

            // Port B pin.
            bip_pin u_b (
                .clk_in(clk_in),
                .rst_in(rst_in),
                .dir_in(b_dir_r[gi]),
                .opt_in(b_opt_r[gi]),
                .latch_in(b_latch_r[gi]),
                .alt_req_in(b_alt_req_in[gi]),
                .alt_val_in(b_alt_val_in[gi]),
                .pin_in(b_pin_in[gi]),
                .pin_out(b_pin_out[gi]),
                .pin_oe_out(b_pin_oe_out[gi]),
                .pull_up_out(b_pull_up_out[gi]),
                .analog_out(b_analog_out[gi]),
                .read_bit_out(b_read[gi]),
                .fall_out(b_fall[gi]),
                .rise_out(b_rise[gi]),
                .low_out(b_low[gi])
            );
        end
    endgenerate

    // Port A configuration registers; bit n belongs to pin n.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            a_latch_r <= BIP_RST_PORT;
            a_dir_r <= BIP_RST_PORT;
            a_opt_r <= BIP_RST_PORT;
        end else if (wr_in) begin
            if (addr_in == BIP_OFS_A_DATA) begin
                a_latch_r <= wr_data_in;
            end
            if (addr_in == BIP_OFS_A_DIR) begin
                a_dir_r <= wr_data_in;
            end
            if (addr_in == BIP_OFS_A_OPT) begin
                a_opt_r <= wr_data_in;
            end
        end
    end

    // Port B configuration registers; bit n belongs to pin n.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            b_latch_r <= BIP_RST_PORT;
            b_dir_r <= BIP_RST_PORT;
            b_opt_r <= BIP_RST_PORT;
        end else if (wr_in) begin
            if (addr_in == BIP_OFS_B_DATA) begin
                b_latch_r <= wr_data_in;
            end
            if (addr_in == BIP_OFS_B_DIR) begin
                b_dir_r <= wr_data_in;
            end
            if (addr_in == BIP_OFS_B_OPT) begin
                b_opt_r <= wr_data_in;
            end
        end
    end

    // Interrupt control: trigger selects and global enable.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port_a_level_select_r <= BIP_RST_CTRL[BIP_CTRL_A_LEVEL];
            port_b_polarity_select_r <= BIP_RST_CTRL[BIP_CTRL_B_RISE];
            global_irq_enable_r <= BIP_RST_CTRL[BIP_CTRL_GEN];
        end else if (wr_in && addr_in == BIP_OFS_IRQ_CTRL) begin
            port_a_level_select_r <= wr_data_in[BIP_CTRL_A_LEVEL];
            port_b_polarity_select_r <= wr_data_in[BIP_CTRL_B_RISE];
            global_irq_enable_r <= wr_data_in[BIP_CTRL_GEN];
        end
    end

    // Interrupt mask register, same layout as the status register.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_mask_r <= BIP_RST_MASK;
        end else if (wr_in && addr_in == BIP_OFS_IRQ_MASK) begin
            irq_mask_r <= wr_data_in[1:0];
        end
    end

    // Port A fires on any interrupt pin falling, or held low in level mode.
    assign a_event = port_a_level_select_r ? (|a_low) : (|a_fall);

    // Port B fires on any interrupt pin falling or rising, as selected.
    assign b_event = port_b_polarity_select_r ? (|b_rise) : (|b_fall);

    // Events reach status only while the global enable is set.
    assign events = global_irq_enable_r ? {b_event, a_event} : 2'h0;

    // A status read clears the sticky bits it returned.
    assign stat_rd = rd_in && addr_in == BIP_OFS_IRQ_STAT;

    // A new event in the clearing cycle survives the clear.
    always_comb begin
        irq_stat_nxt = stat_rd ? 2'h0 : irq_stat_r;
        irq_stat_nxt = irq_stat_nxt | events;
    end

    // Sticky status bits.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_stat_r <= BIP_RST_STAT;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // Level interrupt while an unmasked status bit is set.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // Read multiplexer; data reads pick pin or latch per bit.
    always_comb begin
        rd_data_nxt = 8'h00;
        unique case (addr_in)
            BIP_OFS_A_DATA: rd_data_nxt = a_read;
            BIP_OFS_A_DIR: rd_data_nxt = a_dir_r;
            BIP_OFS_A_OPT: rd_data_nxt = a_opt_r;
            BIP_OFS_B_DATA: rd_data_nxt = b_read;
            BIP_OFS_B_DIR: rd_data_nxt = b_dir_r;
            BIP_OFS_B_OPT: rd_data_nxt = b_opt_r;
            BIP_OFS_IRQ_CTRL: begin
                rd_data_nxt[BIP_CTRL_A_LEVEL] = port_a_level_select_r;
                rd_data_nxt[BIP_CTRL_B_RISE] = port_b_polarity_select_r;
                rd_data_nxt[BIP_CTRL_GEN] = global_irq_enable_r;
            end
            BIP_OFS_IRQ_STAT: rd_data_nxt[1:0] = irq_stat_r;
            BIP_OFS_IRQ_MASK: rd_data_nxt[1:0] = irq_mask_r;
            default: rd_data_nxt = 8'h00;
        endcase
    end

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_in) begin
            rd_data_out <= rd_data_nxt;
        end else begin
            rd_data_out <= 8'h00;
        end
    end

endmodule : bip_port

`default_nettype wire

// >>> verilog/bip_pkg.sv
// Purpose: Shared constants for the bidirectional I/O port block.
// Assumes: One core clock; registers reached over a plain strobe port.
// Notes: Offsets and bit positions below are used by the port module, its checker and the bench.

`default_nettype none

package bip_pkg;

    // Port geometry.
    localparam int BIP_PINS = 8;
    localparam int BIP_ADDR_W = 4;
    localparam int BIP_DATA_W = 8;

    // Register offsets, port A.
    localparam logic [3:0] BIP_OFS_A_DATA = 4'h0;
    localparam logic [3:0] BIP_OFS_A_DIR = 4'h1;
    localparam logic [3:0] BIP_OFS_A_OPT = 4'h2;

    // Register offsets, port B.
    localparam logic [3:0] BIP_OFS_B_DATA = 4'h4;
    localparam logic [3:0] BIP_OFS_B_DIR = 4'h5;
    localparam logic [3:0] BIP_OFS_B_OPT = 4'h6;

    // Register offsets, interrupt control, status and mask.
    localparam logic [3:0] BIP_OFS_IRQ_CTRL = 4'h8;
    localparam logic [3:0] BIP_OFS_IRQ_STAT = 4'h9;
    localparam logic [3:0] BIP_OFS_IRQ_MASK = 4'ha;

    // Interrupt control bit positions.
    localparam int BIP_CTRL_A_LEVEL = 0;
    localparam int BIP_CTRL_B_RISE = 1;
    localparam int BIP_CTRL_GEN = 2;

    // Status and mask bit positions.
    localparam int BIP_STAT_A = 0;
    localparam int BIP_STAT_B = 1;

    // Reset values.
    localparam logic [7:0] BIP_RST_PORT = 8'h00;
    localparam logic [2:0] BIP_RST_CTRL = 3'h0;
    localparam logic [1:0] BIP_RST_STAT = 2'h0;
    localparam logic [1:0] BIP_RST_MASK = 2'h0;

endpackage : bip_pkg

`default_nettype wire

// >>> verilog/bip_pin.sv
// Purpose: One I/O pin: mode decode, registered drive and trigger detection.
// Assumes: pin_in is synchronous to clk_in.
// Notes: Drive outputs lag the configuration registers by one clock.

`timescale 1ns/1ps
`default_nettype none

module bip_pin (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Configuration bits of this pin.
    input wire logic dir_in,
    input wire logic opt_in,
    input wire logic latch_in,
    // Alternate function from a peripheral.
    input wire logic alt_req_in,
    input wire logic alt_val_in,
    // Pin level seen from outside.
    input wire logic pin_in,
    // Registered pin drive.
    output logic pin_out,
    output logic pin_oe_out,
    output logic pull_up_out,
    output logic analog_out,
    // Combinational read value and trigger terms.
    output logic read_bit_out,
    output logic fall_out,
    output logic rise_out,
    output logic low_out
);

    logic irq_cfg;
    logic drive_val;
    logic prev_r;

    // Input with pull-up and interrupt is the only interrupt-capable code.
    assign irq_cfg = !dir_in && opt_in && !latch_in;

    // The alternate value replaces the latch whenever requested; the enable still needs an output pin.
    assign drive_val = alt_req_in ? alt_val_in : latch_in;

    // Reads return the pin level for inputs and the latch for outputs.
    assign read_bit_out = dir_in ? latch_in : pin_in;

    // Trigger terms, qualified by the pin's own interrupt configuration.
    assign fall_out = irq_cfg && prev_r && !pin_in;
    assign rise_out = irq_cfg && !prev_r && pin_in;
    assign low_out = irq_cfg && !pin_in;

    // Previous pin level for edge detection; idles high like a pulled-up pin.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= pin_in;
        end
    end

    // Output driver: push-pull drives both levels, open-drain only pulls low.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_out <= 1'b0;
            pin_oe_out <= 1'b0;
        end else begin
            pin_out <= drive_val;
            pin_oe_out <= dir_in && (opt_in || !drive_val);
        end
    end

    // Input options: pull-up for codes 00 and 10, analog path for code 11.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pull_up_out <= 1'b1;
            analog_out <= 1'b0;
        end else begin
            pull_up_out <= !dir_in && !latch_in;
            analog_out <= !dir_in && opt_in && latch_in;
        end
    end

endmodule : bip_pin

`default_nettype wire

// >>> sim/bip_port_properties.sv
// Purpose: Port-level checker for the two-port I/O block.
// Assumes: Shadow registers follow every accepted port and mask write.
// Notes: Status reads are judged by the bench; control reads are checked by neither.
`timescale 1ns/1ps
`default_nettype none
module bip_port_checker
    import bip_pkg::*;
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Register port.
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    // Pins.
    input wire logic [7:0] a_pin_in,
    input wire logic [7:0] a_pin_out,
    input wire logic [7:0] a_pin_oe_out,
    input wire logic [7:0] a_pull_up_out,
    input wire logic [7:0] a_analog_out,
    input wire logic [7:0] b_pin_in,
    input wire logic [7:0] b_pin_out,
    input wire logic [7:0] b_pin_oe_out,
    input wire logic [7:0] b_pull_up_out,
    input wire logic [7:0] b_analog_out,
    // Alternate functions and interrupt.
    input wire logic [7:0] a_alt_req_in,
    input wire logic [7:0] a_alt_val_in,
    input wire logic [7:0] b_alt_req_in,
    input wire logic [7:0] b_alt_val_in,
    input wire logic irq_out
);
    logic [1:0][2:0][7:0] sh_r;
    logic [1:0] mask_r;
    logic [15:0] dir, opt, lat, req, val, dat;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Shadow copies of the port and mask registers.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sh_r <= 48'h0;
            mask_r <= BIP_RST_MASK;
        end else if (wr_in) begin
            if (!addr_in[3] && addr_in[1:0] != 2'h3) begin
                sh_r[addr_in[2]][addr_in[1:0]] <= wr_data_in;
            end
            if (addr_in == BIP_OFS_IRQ_MASK) begin
                mask_r <= wr_data_in[1:0];
            end
        end
    end
    // Expected drive and read terms, port B in the upper byte.
    assign dir = {sh_r[1][1], sh_r[0][1]};
    assign opt = {sh_r[1][2], sh_r[0][2]};
    assign lat = {sh_r[1][0], sh_r[0][0]};
    assign req = {b_alt_req_in, a_alt_req_in} & dir;
    assign val = (req & {b_alt_val_in, a_alt_val_in}) | (~req & lat);
    assign dat = (dir & lat) | (~dir & {b_pin_in, a_pin_in});
    sequence s_rd_plain;
        rd_in && addr_in != BIP_OFS_IRQ_CTRL && addr_in != BIP_OFS_IRQ_STAT;
    endsequence
    sequence s_mask_off;
        mask_r == 2'h0 ##1 mask_r == 2'h0;
    endsequence
    property p_rd_value;
        s_rd_plain |=> rd_data_out == $past(addr_in == BIP_OFS_IRQ_MASK ? {6'h00, mask_r}
            : addr_in[3] || addr_in[1:0] == 2'h3 ? 8'h00
            : addr_in[1:0] != 2'h0 ? sh_r[addr_in[2]][addr_in[1:0]]
            : addr_in[2] ? dat[15:8] : dat[7:0]);
    endproperty
    property p_oe;
        {b_pin_oe_out, a_pin_oe_out} == $past(dir & (opt | ~val));
    endproperty
    property p_drive;
        (({b_pin_out, a_pin_out} ^ $past(val)) & {b_pin_oe_out, a_pin_oe_out}) == 16'h0;
    endproperty
    property p_pull;
        {b_pull_up_out, a_pull_up_out} == $past(~dir & ~lat);
    endproperty
    property p_analog;
        {b_analog_out, a_analog_out} == $past(~dir & opt & lat);
    endproperty
    property p_reset;
        $fell(rst_in) |-> {b_pull_up_out, a_pull_up_out} == 16'hffff
            && {b_pin_oe_out, a_pin_oe_out} == 16'h0 && !irq_out;
    endproperty
    property p_irq_mask;
        s_mask_off |-> !irq_out;
    endproperty
    property p_irq_cause;
        $rose(irq_out) |-> $past(mask_r) != 2'h0;
    endproperty
    a_rd_value: assert property (p_rd_value) else $error("read data wrong");
    a_oe: assert property (p_oe) else $error("output enable wrong");
    a_drive: assert property (p_drive) else $error("driven level wrong");
    a_pull: assert property (p_pull) else $error("pull-up wrong");
    a_analog: assert property (p_analog) else $error("analog select wrong");
    a_reset: assert property (p_reset) else $error("reset state wrong");
    a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt seen");
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without mask");
endmodule : bip_port_checker
bind bip_port bip_port_checker i_bip_port_checker (.clk_in, .rst_in, .addr_in, .wr_data_in,
    .wr_in, .rd_in, .rd_data_out, .a_pin_in, .a_pin_out, .a_pin_oe_out, .a_pull_up_out,
    .a_analog_out, .b_pin_in, .b_pin_out, .b_pin_oe_out, .b_pull_up_out, .b_analog_out,
    .a_alt_req_in, .a_alt_val_in, .b_alt_req_in, .b_alt_val_in, .irq_out);
`default_nettype wire

// >>> sim/bip_pin_model.sv
// Purpose: External circuit on eight port pins.
// Assumes: The bench never drives a pin the port drives.
// Notes: An undriven pin without pull-up wanders every clock.
`timescale 1ns/1ps
`default_nettype none
module bip_pin_model (
    // Clock.
    input wire logic clk_in,
    // Drive from the port.
    input wire logic [7:0] pin_out_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pull_up_in,
    // External source set by the bench.
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    // Resolved level.
    output logic [7:0] level_out
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] free;
    // Port drive wins, then the source, then the pull-up; else the pin floats.
    assign free = ~oe_in & ~ext_en_in;
    assign level_out = (oe_in & pin_out_in) | (~oe_in & ext_en_in & ext_val_in)
        | (free & pull_up_in) | (free & ~pull_up_in & ~last_r);
    // Last level, so a floating pin never holds a stable value.
    always_ff @(posedge clk_in) begin
        last_r <= level_out;
    end
endmodule : bip_pin_model
`default_nettype wire

// >>> sim/tb_top.sv
// Purpose: Self-checking bench for the two-port I/O block.
// Assumes: Pin levels come from the external circuit models.
// Notes: Register reads carry their expected values.
`timescale 1ns/1ps
`default_nettype none
module tb_top import bip_pkg::*; ;
    logic clk_in, rst_in, wr_in, rd_in, irq_out;
    logic [3:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out, a_pin_in, a_pin_out, a_pin_oe_out, a_pull_up_out;
    logic [7:0] a_analog_out, b_pin_in, b_pin_out, b_pin_oe_out, b_pull_up_out, b_analog_out;
    logic [7:0] a_alt_req_in, a_alt_val_in, b_alt_req_in, b_alt_val_in;
    logic [7:0] a_ext_en, a_ext_val, b_ext_en, b_ext_val;
    int n_fail = 0;
    int comparisons = 0;
    bip_port i_bip_port (.clk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
        .a_pin_in, .a_pin_out, .a_pin_oe_out, .a_pull_up_out, .a_analog_out, .b_pin_in,
        .b_pin_out, .b_pin_oe_out, .b_pull_up_out, .b_analog_out, .a_alt_req_in,
        .a_alt_val_in, .b_alt_req_in, .b_alt_val_in, .irq_out);
    bip_pin_model i_bip_pin_model_a (.clk_in, .pin_out_in(a_pin_out), .oe_in(a_pin_oe_out),
        .pull_up_in(a_pull_up_out), .ext_en_in(a_ext_en), .ext_val_in(a_ext_val),
        .level_out(a_pin_in));
    bip_pin_model i_bip_pin_model_b (.clk_in, .pin_out_in(b_pin_out), .oe_in(b_pin_oe_out),
        .pull_up_in(b_pull_up_out), .ext_en_in(b_ext_en), .ext_val_in(b_ext_val),
        .level_out(b_pin_in));
    // Free-running core clock.
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons += 1;
        if (seen !== exp) begin
            n_fail += 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        check({8'h00, rd_data_out}, {8'h00, exp});
    endtask : rd
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #1;
    endtask : settle
    // Waits a bounded number of clocks for the interrupt; a timeout is a mismatch and ends the run.
    task automatic wait_irq;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_in);
            #1;
            if (irq_out === 1'b1) begin
                break;
            end
        end
        check({15'h0000, irq_out}, 16'h0001);
        if (irq_out !== 1'b1) begin
            conclude();
        end
    endtask : wait_irq
    // Main sequence of register calls and pin stimulus.
    initial begin
        {rst_in, wr_in, rd_in, addr_in, wr_data_in} = 15'h4000;
        {a_alt_req_in, a_alt_val_in, b_alt_req_in, b_alt_val_in} = 32'h0;
        {a_ext_en, a_ext_val, b_ext_en, b_ext_val} = 32'h0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        #1;
        check({a_pull_up_out, b_pull_up_out}, 16'hffff);
        check({a_pin_oe_out, b_pin_oe_out}, 16'h0000);
        rd(BIP_OFS_A_DATA, 8'hff);
        rd(BIP_OFS_B_DIR, 8'h00);
        rd(BIP_OFS_A_OPT, 8'h00);
        rd(4'h3, 8'h00);
        wr(BIP_OFS_A_DIR, 8'hff);
        wr(BIP_OFS_A_OPT, 8'h0f);
        wr(BIP_OFS_A_DATA, 8'ha5);
        settle();
        check({8'h00, a_pin_oe_out}, 16'h005f);
        check({8'h00, a_pin_out & a_pin_oe_out}, 16'h0005);
        rd(BIP_OFS_A_DATA, 8'ha5);
        b_ext_en <= 8'hf0;
        b_ext_val <= 8'h90;
        wr(BIP_OFS_B_DIR, 8'h0f);
        wr(BIP_OFS_B_DATA, 8'hf0);
        settle();
        rd(BIP_OFS_B_DATA, 8'h90);
        check({8'h00, b_pull_up_out}, 16'h0000);
        b_ext_en <= 8'h00;
        wr(BIP_OFS_B_DIR, 8'h00);
        wr(BIP_OFS_B_OPT, 8'h0c);
        wr(BIP_OFS_B_DATA, 8'h0a);
        settle();
        check({b_pull_up_out, b_analog_out}, 16'hf508);
        wr(BIP_OFS_A_DIR, 8'h00);
        wr(BIP_OFS_A_OPT, 8'h01);
        wr(BIP_OFS_A_DATA, 8'h00);
        wr(BIP_OFS_IRQ_MASK, 8'h03);
        a_ext_en <= 8'h01;
        settle();
        rd(BIP_OFS_IRQ_STAT, 8'h00);
        a_ext_en <= 8'h00;
        wr(BIP_OFS_IRQ_CTRL, 8'h04);
        settle();
        a_ext_en <= 8'h01;
        wait_irq();
        rd(BIP_OFS_IRQ_STAT, 8'h01);
        rd(BIP_OFS_IRQ_STAT, 8'h00);
        wr(BIP_OFS_IRQ_CTRL, 8'h05);
        wait_irq();
        rd(BIP_OFS_IRQ_STAT, 8'h01);
        a_ext_en <= 8'h00;
        settle();
        rd(BIP_OFS_IRQ_STAT, 8'h01);
        rd(BIP_OFS_IRQ_STAT, 8'h00);
        wr(BIP_OFS_IRQ_CTRL, 8'h06);
        b_ext_en <= 8'h04;
        settle();
        rd(BIP_OFS_IRQ_STAT, 8'h00);
        wr(BIP_OFS_IRQ_MASK, 8'h01);
        b_ext_en <= 8'h00;
        settle();
        check({15'h0, irq_out}, 16'h0000);
        rd(BIP_OFS_IRQ_STAT, 8'h02);
        wr(BIP_OFS_IRQ_MASK, 8'h03);
        wr(BIP_OFS_IRQ_CTRL, 8'h04);
        b_ext_en <= 8'h04;
        wait_irq();
        rd(BIP_OFS_IRQ_STAT, 8'h02);
        @(posedge clk_in);
        a_alt_val_in <= 8'h3c;
        a_alt_req_in <= 8'hff;
        settle();
        check({8'h00, a_pin_oe_out}, 16'h0000);
        wr(BIP_OFS_A_OPT, 8'hff);
        wr(BIP_OFS_A_DIR, 8'hff);
        settle();
        check({a_pin_out, a_pin_oe_out}, 16'h3cff);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
